// [hdl/mwsh_pkg.sv]
// Constants, types and register map of the multiword shift unit
package mwsh_pkg;

  localparam int WORD_W  = 16;
  localparam int WORD_MSB = 15;
  localparam int FC_W    = 12;
  localparam int PADDR_W = 8;

  // APB register byte offsets
  localparam logic [PADDR_W-1:0] OFS_CMD    = 8'h00;
  localparam logic [PADDR_W-1:0] OFS_CTRL   = 8'h04;
  localparam logic [PADDR_W-1:0] OFS_FIRST  = 8'h08;
  localparam logic [PADDR_W-1:0] OFS_LAST   = 8'h0C;
  localparam logic [PADDR_W-1:0] OFS_SRC    = 8'h10;
  localparam logic [PADDR_W-1:0] OFS_STATUS = 8'h14;

  // Function codes, three decimal digits held as BCD
  localparam logic [FC_W-1:0] FC_BIT_SHIFT  = 12'h084;
  localparam logic [FC_W-1:0] FC_WORD_SHIFT = 12'h016;
  localparam logic [FC_W-1:0] FC_ZF_LEFT    = 12'h025;
  localparam logic [FC_W-1:0] FC_ZF_RIGHT   = 12'h026;

  // Reversible shift control word bits
  localparam int CTL_CLEAR  = 15;
  localparam int CTL_SHIFT  = 14;
  localparam int CTL_SERIAL = 13;
  localparam int CTL_DIR    = 12;
  localparam logic DIR_RIGHT = 1'b1;

  // Status register bits
  localparam int STS_ERROR = 0;
  localparam int STS_CARRY = 1;
  localparam int STS_ZERO  = 2;
  localparam int STS_NEG   = 3;
  localparam int STS_BADCMD = 4;
  localparam int STS_BUSY  = 5;

  localparam logic [WORD_W-1:0] WORD_ZERO  = 16'h0000;
  localparam logic [WORD_W-1:0] ADDR_ONE   = 16'h0001;
  localparam logic [31:0]       RDATA_ZERO = 32'h0000_0000;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_READ = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_DATA = 5'b01000,
    ST_FILL = 5'b10000
  } mwsh_state_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_BITL = 3'h1,
    OP_BITR = 3'h2,
    OP_WORD = 3'h3,
    OP_CLR  = 3'h4,
    OP_ASL  = 3'h5,
    OP_ASR  = 3'h6
  } mwsh_op_t;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [WORD_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } mwsh_mem_req_t;

  typedef struct packed {
    logic error;
    logic carry;
    logic zero;
    logic neg;
  } mwsh_flags_t;

  typedef struct packed {
    mwsh_state_t       state;
    mwsh_op_t          op;
    mwsh_mem_req_t     mem;
    mwsh_flags_t       flags;
    logic [WORD_W-1:0] ctrl;
    logic [WORD_W-1:0] first;
    logic [WORD_W-1:0] last;
    logic [WORD_W-1:0] src;
    logic [WORD_W-1:0] cur;
    logic [FC_W-1:0]   code;
    logic              chain;
    logic              prev_shift;
    logic              cmd_bad;
    logic              busy;
    logic              done;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } mwsh_regs_t;

  localparam mwsh_regs_t REGS_RESET = '{state: ST_IDLE, op: OP_NONE, default: '0};

endpackage

// [hdl/mwsh_bit_shifter.sv]
// One-bit shift of a 16-bit word with a fill bit and the bit shifted out
`timescale 1ns/100ps
module mwsh_bit_shifter
  import mwsh_pkg::*;
(
  input  wire logic [WORD_W-1:0] word_in,   // Word to shift
  input  wire logic              dir_right, // 1 shifts toward bit 0
  input  wire logic              fill_bit,  // Bit entering the vacated end
  output logic      [WORD_W-1:0] word_out,  // Shifted word
  output logic                   out_bit    // Bit leaving the word
);

  assign word_out = (dir_right == DIR_RIGHT) ? {fill_bit, word_in[WORD_MSB:1]}
                                              : {word_in[WORD_MSB-1:0], fill_bit};
  assign out_bit  = (dir_right == DIR_RIGHT) ? word_in[0] : word_in[WORD_MSB];

endmodule

// [hdl/mwsh_shift_unit.sv]
// Multiword shift unit: APB command slave, memory sequencer and flags
//
// Function
// [RL1] A rising shift-request bit moves the whole first..last range one bit in the chosen direction.
// [RL2] A left reversible shift feeds the serial bit into bit 0 of the first word and bit 15 of the last to carry.
// [RL3] A right reversible shift feeds the serial bit into bit 15 of the last word and bit 0 of the first to carry.
// [RL4] While the clear bit is set the range and carry are zeroed and shift requests are ignored.
// [RL5] A direction bit of one means right, zero means left.
// [RL6] Both range operations set the error flag when first exceeds last and clear it otherwise.
// [RL7] The word shift moves each word one place toward last, puts the source in first and drops last.
// [RL8] Function code 084 selects the reversible bit shift and 016 the word shift.
// [RL9] Function code 025 selects the zero-fill left shift and 026 the zero-fill right shift.
// [RL10] The zero-fill left shift inserts zero at bit 0 and sends the old bit 15 to carry.
// [RL11] After a zero-fill left shift negative follows bit 15, zero follows the result and error clears.
// [RL12] The zero-fill right shift inserts zero at bit 15 and sends the old bit 0 to carry.
// [RL13] After a zero-fill right shift zero follows the result and negative and error clear.
// [RL14] Software keeps first and last inside one data area.
// [RL15] Power is kept applied for the whole of a long range shift.
// [RL16] The word shift works from last toward first so no source word is overwritten early.
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/100ps
module mwsh_shift_unit
  import mwsh_pkg::*;
(
  input  wire logic               sys_clk,          // 25 MHz clock
  input  wire logic               rst_n,            // Asynchronous reset, active low
  input  wire logic               psel,             // APB select
  input  wire logic               penable,          // APB enable
  input  wire logic               pwrite,           // APB write
  input  wire logic [PADDR_W-1:0] paddr,            // APB byte address
  input  wire logic [31:0]        pwdata,           // APB write data
  output logic      [31:0]        prdata,           // APB read data
  output logic                    pready,           // APB ready
  output logic                    pslverr,          // APB error
  output logic                    mem_rd,           // Data memory read strobe
  output logic                    mem_wr,           // Data memory write strobe
  output logic      [WORD_W-1:0]  mem_addr,         // Data memory word address
  output logic      [WORD_W-1:0]  mem_wdata,        // Data memory write data
  input  wire logic [WORD_W-1:0]  mem_rdata,        // Read data, valid the cycle after mem_rd
  output logic                    busy,             // Operation in progress
  output logic                    op_done,          // One-cycle end of operation
  output logic                    error_flag,       // Range or operand error
  output logic                    carry_flag,       // Bit shifted out
  output logic                    zero_result_flag, // Result word is zero
  output logic                    negative_flag     // Result bit 15 set
);

  mwsh_regs_t        q;
  mwsh_regs_t        d;
  logic              apb_access;
  logic              wr_commit;
  logic              start;
  logic [FC_W-1:0]   cmd_code;
  logic [WORD_W-1:0] sh_word;
  logic              sh_out;
  logic              sh_right;
  logic              sh_fill;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic reg_hit(input logic [PADDR_W-1:0] a);
    begin
      reg_hit = (a == OFS_CMD) || (a == OFS_CTRL) || (a == OFS_FIRST) ||
                (a == OFS_LAST) || (a == OFS_SRC) || (a == OFS_STATUS);
    end
  endfunction

  function automatic logic range_bad(input logic [WORD_W-1:0] f, input logic [WORD_W-1:0] l);
    begin
      range_bad = (f > l);
    end
  endfunction

  function automatic logic [WORD_W-1:0] step(input logic [WORD_W-1:0] a, input logic down);
    begin
      step = down ? (a - ADDR_ONE) : (a + ADDR_ONE);
    end
  endfunction

  assign cmd_code = pwdata[FC_W-1:0];
  assign sh_right = (q.op == OP_BITR) || (q.op == OP_ASR);
  assign sh_fill  = ((q.op == OP_BITL) || (q.op == OP_BITR)) ? q.chain : 1'b0;

  mwsh_bit_shifter u_shifter
  (
    .word_in   (mem_rdata),
    .dir_right (sh_right),
    .fill_bit  (sh_fill),
    .word_out  (sh_word),
    .out_bit   (sh_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    d          = q;
    d.mem.rd   = 1'b0;
    d.mem.wr   = 1'b0;
    d.done     = 1'b0;
    start      = 1'b0;
    apb_access = psel & penable & ~q.pready;
    wr_commit  = psel & penable & q.pready & pwrite & ~q.pslverr;
    d.pready   = apb_access;
    d.pslverr  = 1'b0;
    if (apb_access)
    begin
      d.prdata = RDATA_ZERO;
      // Writes while busy are refused so operands stay stable
      if (!reg_hit(paddr) || (pwrite && q.busy))
      begin
        d.pslverr = 1'b1;
      end
      else if (!pwrite)
      begin
        case (paddr)
          OFS_CMD:    d.prdata[FC_W-1:0] = q.code;
          OFS_CTRL:   d.prdata[WORD_MSB:0] = q.ctrl;
          OFS_FIRST:  d.prdata[WORD_MSB:0] = q.first;
          OFS_LAST:   d.prdata[WORD_MSB:0] = q.last;
          OFS_SRC:    d.prdata[WORD_MSB:0] = q.src;
          default:
          begin
            d.prdata[STS_ERROR]  = q.flags.error;
            d.prdata[STS_CARRY]  = q.flags.carry;
            d.prdata[STS_ZERO]   = q.flags.zero;
            d.prdata[STS_NEG]    = q.flags.neg;
            d.prdata[STS_BADCMD] = q.cmd_bad;
            d.prdata[STS_BUSY]   = q.busy;
          end
        endcase
      end
    end
    if (wr_commit)
    begin
      case (paddr)
        OFS_CMD:
        begin
          d.code = cmd_code;
          start  = 1'b1;
        end
        OFS_CTRL:  d.ctrl  = pwdata[WORD_MSB:0];
        OFS_FIRST: d.first = pwdata[WORD_MSB:0];
        OFS_LAST:  d.last  = pwdata[WORD_MSB:0];
        OFS_SRC:   d.src   = pwdata[WORD_MSB:0];
        default:   d.code  = q.code;
      endcase
    end

    unique case (q.state)
      ST_IDLE:
      begin
        if (start)
        begin
          d.cmd_bad = 1'b0;
          case (cmd_code)
            // [RL8] reversible shift decode
            FC_BIT_SHIFT:
            begin
              d.prev_shift = q.ctrl[CTL_SHIFT];
              // [RL6] range error check
              if (range_bad(q.first, q.last))
              begin
                d.flags.error = 1'b1;
                d.done        = 1'b1;
              end
              else
              begin
                d.flags.error = 1'b0;
                // [RL4] clear beats shift
                if (q.ctrl[CTL_CLEAR])
                begin
                  d.op          = OP_CLR;
                  d.cur         = q.first;
                  d.flags.carry = 1'b0;
                  d.state       = ST_FILL;
                  d.busy        = 1'b1;
                end
                // [RL1] rising request only
                else if (q.ctrl[CTL_SHIFT] && !q.prev_shift)
                begin
                  d.chain = q.ctrl[CTL_SERIAL];
                  d.state = ST_READ;
                  d.busy  = 1'b1;
                  // [RL5] direction bit meaning
                  if (q.ctrl[CTL_DIR] == DIR_RIGHT)
                  begin
                    d.op  = OP_BITR;
                    d.cur = q.last;
                  end
                  else
                  begin
                    d.op  = OP_BITL;
                    d.cur = q.first;
                  end
                end
                else
                begin
                  d.done = 1'b1;
                end
              end
            end
            // [RL8] word shift decode
            FC_WORD_SHIFT:
            begin
              // [RL6] range error check
              if (range_bad(q.first, q.last))
              begin
                d.flags.error = 1'b1;
                d.done        = 1'b1;
              end
              else
              begin
                d.flags.error = 1'b0;
                d.op          = OP_WORD;
                d.busy        = 1'b1;
                // [RL16] start at the last word
                d.cur         = q.last;
                d.state       = (q.first == q.last) ? ST_FILL : ST_READ;
              end
            end
            // [RL9] zero-fill decode
            FC_ZF_LEFT, FC_ZF_RIGHT:
            begin
              d.op    = (cmd_code == FC_ZF_LEFT) ? OP_ASL : OP_ASR;
              d.cur   = q.first;
              d.state = ST_READ;
              d.busy  = 1'b1;
            end
            default:
            begin
              d.cmd_bad = 1'b1;
              d.done    = 1'b1;
            end
          endcase
        end
      end
      ST_READ:
      begin
        d.mem.rd   = 1'b1;
        // [RL16] word shift reads the word below
        d.mem.addr = step(q.cur, q.op == OP_WORD) ;
        if (q.op != OP_WORD)
        begin
          d.mem.addr = q.cur;
        end
        d.state    = ST_WAIT;
      end
      ST_WAIT:
      begin
        d.state = ST_DATA;
      end
      ST_DATA:
      begin
        d.mem.wr    = 1'b1;
        d.mem.addr  = q.cur;
        d.mem.wdata = sh_word;
        d.chain     = sh_out;
        case (q.op)
          // [RL2] [RL3] left pass first toward last, right pass last toward first
          OP_BITL, OP_BITR:
          begin
            if (q.cur == ((q.op == OP_BITL) ? q.last : q.first))
            begin
              // [RL3] carry takes last bit out
              d.flags.carry = sh_out;
              d.state       = ST_IDLE;
              d.busy        = 1'b0;
              d.done        = 1'b1;
            end
            else
            begin
              d.cur   = step(q.cur, q.op == OP_BITR);
              d.state = ST_READ;
            end
          end
          // [RL7] copy word one place up
          OP_WORD:
          begin
            d.mem.wdata = mem_rdata;
            d.cur       = step(q.cur, 1'b1);
            d.state     = (step(q.cur, 1'b1) == q.first) ? ST_FILL : ST_READ;
          end
          // [RL10] [RL11] zero-fill left flags
          OP_ASL:
          begin
            d.flags.error = 1'b0;
            d.flags.carry = sh_out;
            d.flags.zero  = (sh_word == WORD_ZERO);
            d.flags.neg   = sh_word[WORD_MSB];
            d.state       = ST_IDLE;
            d.busy        = 1'b0;
            d.done        = 1'b1;
          end
          // [RL12] [RL13] zero-fill right flags
          default:
          begin
            d.flags.error = 1'b0;
            d.flags.carry = sh_out;
            d.flags.zero  = (sh_word == WORD_ZERO);
            d.flags.neg   = 1'b0;
            d.state       = ST_IDLE;
            d.busy        = 1'b0;
            d.done        = 1'b1;
          end
        endcase
      end
      ST_FILL:
      begin
        d.mem.wr   = 1'b1;
        d.mem.addr = q.cur;
        // [RL4] zero the range on clear, [RL7] source into first for word shift
        d.mem.wdata = (q.op == OP_CLR) ? WORD_ZERO : q.src;
        if ((q.op == OP_WORD) || (q.cur == q.last))
        begin
          d.state = ST_IDLE;
          d.busy  = 1'b0;
          d.done  = 1'b1;
        end
        else
        begin
          d.cur = step(q.cur, 1'b0);
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= REGS_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata           = q.prdata;
  assign pready           = q.pready;
  assign pslverr          = q.pslverr;
  assign mem_rd           = q.mem.rd;
  assign mem_wr           = q.mem.wr;
  assign mem_addr         = q.mem.addr;
  assign mem_wdata        = q.mem.wdata;
  assign busy             = q.busy;
  assign op_done          = q.done;
  assign error_flag       = q.flags.error;
  assign carry_flag       = q.flags.carry;
  assign zero_result_flag = q.flags.zero;
  assign negative_flag    = q.flags.neg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_data(mwsh_op_t o);
    (q.state == ST_DATA) && (q.op == o);
  endsequence

  sequence s_start(logic [FC_W-1:0] c);
    start && (cmd_code == c);
  endsequence

  property p_shift_start;
    s_start(FC_BIT_SHIFT) ##0 (!q.ctrl[CTL_CLEAR] && q.ctrl[CTL_SHIFT] && !q.prev_shift
      && !range_bad(q.first, q.last)) |=> (q.op == (q.ctrl[CTL_DIR] ? OP_BITR : OP_BITL)) && busy;
  endproperty
  a_shift_start: assert property (p_shift_start) else $error("shift request not started"); // [RL1] [RL5]

  property p_bitl;
    s_data(OP_BITL) |=> mem_wr && (mem_wdata == {$past(mem_rdata[WORD_MSB-1:0]), $past(q.chain)});
  endproperty
  a_bitl: assert property (p_bitl) else $error("left bit shift data wrong"); // [RL2]

  property p_bitr;
    s_data(OP_BITR) ##0 (q.cur == q.first) |=> mem_wr && op_done && (carry_flag == $past(mem_rdata[0]))
      && (mem_wdata == {$past(q.chain), $past(mem_rdata[WORD_MSB:1])});
  endproperty
  a_bitr: assert property (p_bitr) else $error("right bit shift end wrong"); // [RL3]

  property p_clear;
    (q.state == ST_FILL) && (q.op == OP_CLR) |=> mem_wr && (mem_wdata == WORD_ZERO) && !carry_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("clear wrote nonzero"); // [RL4]

  property p_range_err;
    s_start(FC_WORD_SHIFT) ##0 range_bad(q.first, q.last) |=> error_flag && op_done && !busy;
  endproperty
  a_range_err: assert property (p_range_err) else $error("range error not flagged"); // [RL6]

  property p_word;
    s_data(OP_WORD) |=> mem_wr && (mem_addr == $past(q.cur)) && (mem_wdata == $past(mem_rdata));
  endproperty
  a_word: assert property (p_word) else $error("word shift copy wrong"); // [RL7]

  property p_order;
    (q.state == ST_READ) && (q.op == OP_WORD) |=> mem_rd && (mem_addr == q.cur - ADDR_ONE);
  endproperty
  a_order: assert property (p_order) else $error("word shift read order wrong"); // [RL16]

  property p_decode;
    s_start(FC_ZF_RIGHT) |=> (q.op == OP_ASR) ##3 op_done;
  endproperty
  a_decode: assert property (p_decode) else $error("zero-fill right decode wrong"); // [RL9]

  property p_asl;
    s_data(OP_ASL) |=> (mem_wdata == {$past(mem_rdata[WORD_MSB-1:0]), 1'b0}) && (carry_flag == $past(mem_rdata[WORD_MSB]))
      && (negative_flag == mem_wdata[WORD_MSB]) && (zero_result_flag == (mem_wdata == WORD_ZERO)) && !error_flag;
  endproperty
  a_asl: assert property (p_asl) else $error("zero-fill left result wrong"); // [RL10] [RL11]

  property p_asr;
    s_data(OP_ASR) |=> (mem_wdata == {1'b0, $past(mem_rdata[WORD_MSB:1])}) && (carry_flag == $past(mem_rdata[0]))
      && !negative_flag && (zero_result_flag == (mem_wdata == WORD_ZERO)) && !error_flag;
  endproperty
  a_asr: assert property (p_asr) else $error("zero-fill right result wrong"); // [RL12] [RL13]

  property p_bitcode;
    s_start(FC_BIT_SHIFT) |=> (q.code == FC_BIT_SHIFT) && !q.cmd_bad;
  endproperty
  a_bitcode: assert property (p_bitcode) else $error("code 084 rejected"); // [RL8]

endmodule

// [dv/mwsh_mem_model.sv]
// Word memory model answering reads one cycle after the strobe
`timescale 1ns/100ps
module mwsh_mem_model
  import mwsh_pkg::*;
(
  input  wire logic              sys_clk,   // Clock
  input  wire logic              mem_rd,    // Read strobe
  input  wire logic              mem_wr,    // Write strobe
  input  wire logic [WORD_W-1:0] mem_addr,  // Word address
  input  wire logic [WORD_W-1:0] mem_wdata, // Write data
  output logic      [WORD_W-1:0] mem_rdata  // Read data
);
  logic [WORD_W-1:0] m [256];
  logic [WORD_W-1:0] q_r;
  logic              vld_r;

  always @(posedge sys_clk)
  begin
    vld_r <= mem_rd;
    if (mem_rd)
      q_r <= m[mem_addr[7:0]];
    if (mem_wr)
      m[mem_addr[7:0]] <= mem_wdata;
  end

  // Stale data is inverted outside the read slot
  assign mem_rdata = vld_r ? q_r : ~q_r;
endmodule

// [dv/testbench.sv]
// Self-checking bench of the multiword shift unit
`timescale 1ns/100ps
module testbench
  import mwsh_pkg::*;
;
  typedef struct packed {logic [FC_W-1:0] code; logic [15:0] din; logic [15:0] dout; logic [2:0] fl;} mwsh_row_t;
  localparam logic [47:0] INIT3 = 48'hC003_0F0F_8421;
  mwsh_row_t rows [6] = '{
    '{FC_ZF_LEFT, 16'h8001, 16'h0002, 3'h4}, '{FC_ZF_LEFT, 16'h8000, 16'h0000, 3'h6},
    '{FC_ZF_LEFT, 16'h4000, 16'h8000, 3'h1}, '{FC_ZF_RIGHT, 16'h0001, 16'h0000, 3'h6},
    '{FC_ZF_RIGHT, 16'hFFFF, 16'h7FFF, 3'h4}, '{FC_ZF_RIGHT, 16'h8000, 16'h4000, 3'h0}};
  logic               sys_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [PADDR_W-1:0] paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0000_0000;
  logic [31:0]        prdata;
  logic [31:0]        rd;
  logic               pready, pslverr, mem_rd, mem_wr, busy, op_done, err;
  logic               error_flag, carry_flag, zero_result_flag, negative_flag;
  logic [WORD_W-1:0]  mem_addr, mem_wdata, mem_rdata;
  int                 n_fail = 0;
  int                 checks = 0;

  always #20 sys_clk = ~sys_clk;

  mwsh_shift_unit dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .busy, .op_done, .error_flag,
    .carry_flag, .zero_result_flag, .negative_flag);
  mwsh_mem_model mem (.sys_clk, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d);
    int i;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge sys_clk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1)
    begin
      n_fail++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wait_done();
    int i;
    for (i = 0; i < 300 && op_done !== 1'b1; i++)
      @(posedge sys_clk);
    if (op_done !== 1'b1)
    begin
      n_fail++;
      wrap_up();
    end
    @(posedge sys_clk);
  endtask

  task automatic setup(input logic [15:0] f, input logic [15:0] l, input logic [15:0] s, input logic [15:0] c);
    apb(1'b1, OFS_FIRST, {16'h0000, f});
    apb(1'b1, OFS_LAST, {16'h0000, l});
    apb(1'b1, OFS_SRC, {16'h0000, s});
    apb(1'b1, OFS_CTRL, {16'h0000, c});
  endtask

  task automatic run(input logic [FC_W-1:0] code, input logic [15:0] f, input logic [15:0] l,
                     input logic [15:0] s, input logic [15:0] c);
    setup(f, l, s, c);
    apb(1'b1, OFS_CMD, {20'h0_0000, code});
    wait_done();
  endtask

  task automatic ld3();
    mem.m[10] = INIT3[15:0];
    mem.m[11] = INIT3[31:16];
    mem.m[12] = INIT3[47:32];
  endtask

  function automatic logic [47:0] rng();
    return {mem.m[12], mem.m[11], mem.m[10]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk({busy, op_done, pready, error_flag, carry_flag, zero_result_flag, negative_flag}, 64'h0);
    foreach (rows[k])
    begin
      mem.m[5] = rows[k].din;
      run(rows[k].code, 16'h0005, 16'h0005, 16'h0000, 16'h0000);
      chk(mem.m[5], rows[k].dout);
      chk({carry_flag, zero_result_flag, negative_flag, error_flag}, {rows[k].fl, 1'b0});
    end
    // Range kept inside one area by the stimulus
    ld3();
    run(FC_BIT_SHIFT, 16'h000A, 16'h000C, 16'h0000, 16'h4000);
    chk({rng(), carry_flag, error_flag}, {INIT3[46:0], 1'b0, 2'b10});
    run(FC_BIT_SHIFT, 16'h000A, 16'h000C, 16'h0000, 16'h4000);
    chk(rng(), {INIT3[46:0], 1'b0});
    run(FC_BIT_SHIFT, 16'h000A, 16'h000C, 16'h0000, 16'h8000);
    chk({rng(), carry_flag}, 64'h0);
    ld3();
    run(FC_BIT_SHIFT, 16'h000A, 16'h000C, 16'h0000, 16'h7000);
    chk({rng(), carry_flag}, {1'b1, INIT3});
    ld3();
    run(FC_BIT_SHIFT, 16'h000A, 16'h000C, 16'h0000, 16'hC000);
    chk({rng(), carry_flag}, 64'h0);
    ld3();
    run(FC_BIT_SHIFT, 16'h000C, 16'h000A, 16'h0000, 16'h4000);
    chk({rng(), error_flag}, {INIT3, 1'b1});
    // Error left set above must be cleared by a zero-fill shift
    mem.m[5] = 16'h8003;
    run(FC_ZF_LEFT, 16'h0005, 16'h0005, 16'h0000, 16'h0000);
    chk({mem.m[5], carry_flag, error_flag}, {16'h0006, 2'b10});
    run(FC_WORD_SHIFT, 16'h000C, 16'h000A, 16'h1234, 16'h0000);
    chk({rng(), error_flag}, {INIT3, 1'b1});
    mem.m[20] = 16'h1111;
    mem.m[21] = 16'h2222;
    mem.m[22] = 16'h3333;
    mem.m[23] = 16'h4444;
    // Reset stays released for the whole range shift
    run(FC_WORD_SHIFT, 16'h0014, 16'h0017, 16'hABCD, 16'h0000);
    chk({mem.m[23], mem.m[22], mem.m[21], mem.m[20]}, 64'h3333_2222_1111_ABCD);
    chk(error_flag, 1'b0);
    mem.m[31] = 16'h7777;
    run(FC_WORD_SHIFT, 16'h001E, 16'h001E, 16'h5A5A, 16'h0000);
    chk({mem.m[31], mem.m[30]}, 32'h7777_5A5A);
    // Refused accesses and status
    run(12'h099, 16'h0005, 16'h0005, 16'h0000, 16'h0000);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd[STS_BADCMD], 1'b1);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk({err, rd}, 33'h1_0000_0000);
    setup(16'h0014, 16'h0017, 16'hABCD, 16'h0000);
    apb(1'b1, OFS_CMD, {20'h0_0000, FC_WORD_SHIFT});
    apb(1'b1, OFS_SRC, 32'h0000_FFFF);
    chk({err, busy}, 2'b11);
    wait_done();
    chk({mem.m[21], mem.m[20]}, 32'hABCD_ABCD);
    wrap_up();
  end
endmodule
